/* src/sip_cfg.svh */
// Constants of the seven-source interrupt priority controller
`ifndef SIP_CFG_SVH
`define SIP_CFG_SVH

// Number of request sources, also their polling order by index
`define SIP_NSRC        7
`define SIP_SRC_EXT0    0
`define SIP_SRC_TIMER0  1
`define SIP_SRC_EXT1    2
`define SIP_SRC_TIMER1  3
`define SIP_SRC_SERIAL  4
`define SIP_SRC_TIMER2  5
`define SIP_SRC_CA      6

// Register byte offsets on the APB
`define SIP_OFF_ENABLE     12'h0a8
`define SIP_OFF_EN_SET     12'h0ac
`define SIP_OFF_EN_CLR     12'h0b0
`define SIP_OFF_LVL_LOW    12'h0b8
`define SIP_OFF_LVL_HIGH   12'h0bc
`define SIP_OFF_INSERVICE  12'h0c0
`define SIP_OFF_EVT_STAT   12'h0c4
`define SIP_OFF_EVT_MASK   12'h0c8

// Field positions and reset values
`define SIP_GLOBAL_BIT  7
`define SIP_RSVD_BIT    7
`define SIP_ENABLE_RST  8'h00
`define SIP_LVL_RST     7'h00

// Event status bits
`define SIP_NEVT        4
`define SIP_EVT_TAKEN   0
`define SIP_EVT_RETURN  1
`define SIP_EVT_STRAY   2
`define SIP_EVT_RSVD    3

// Vector addresses: base plus step times source index
`define SIP_VEC_BASE    16'h0003
`define SIP_VEC_STEP    16'h0008
`define SIP_VEC_CA      16'h0033

`endif

/* src/sip_ctrl.sv */
// Seven-source interrupt priority controller with APB registers
`timescale 1ns/1ns
`include "sip_cfg.svh"

module sip_ctrl #(
    parameter int AW = 12
) (
    input  wire logic                 pclk,                  // Core clock, 100 MHz
    input  wire logic                 presetn,               // Async reset, active low
    input  wire logic                 psel,                  // APB select
    input  wire logic                 penable,               // APB access phase
    input  wire logic                 pwrite,                // APB direction
    input  wire logic [AW-1:0]        paddr,                 // APB byte address
    input  wire logic [31:0]          pwdata,                // APB write data
    output logic [31:0]               prdata,                // APB read data
    output logic                      pready,                // APB ready
    output logic                      pslverr,               // APB error, unmapped
    input  wire logic                 ext_req0_pin_n,        // External request 0 pin, low active
    input  wire logic                 ext_req1_pin_n,        // External request 1 pin, low active
    input  wire logic                 timer0_overflow_flag,  // Timer 0 request
    input  wire logic                 timer1_overflow_flag,  // Timer 1 request
    input  wire logic                 timer2_overflow_flag,  // Timer 2 overflow
    input  wire logic                 timer2_external_flag,  // Timer 2 external flag
    input  wire logic                 serial_receive_flag,   // Serial receive
    input  wire logic                 serial_send_flag,      // Serial transmit
    input  wire logic                 counter_array_req,     // Counter array global
    output sip_pkg::sip_core_req_s    core_req,              // Vectored request to core
    input  wire logic                 core_ack,              // Core takes shown vector
    input  wire logic                 core_reti,             // Core returns from handler
    output logic                      irq                    // Event interrupt, high level
);
    import sip_pkg::*;

    localparam int NS = `SIP_NSRC;
    localparam int NE = `SIP_NEVT;

    logic [1:0]      ext0_sync_r;        // Pin synchroniser, external 0
    logic [1:0]      ext1_sync_r;        // Pin synchroniser, external 1
    logic [NS-1:0]   raw_req;            // All requests, poll order
    logic [NS-1:0]   gated_req;          // Requests past both enables
    logic [7:0]      src_en_r;           // Source enable register
    logic [NS-1:0]   lvl_low_r;          // Level low bits
    logic [NS-1:0]   lvl_high_r;         // Level high bits
    logic [3:0]      inserv_r;           // In-service flag per level
    logic [NE-1:0]   evt_stat_r;         // Sticky event status
    logic [NE-1:0]   evt_mask_r;         // Event mask
    logic [NE-1:0]   evt_set;            // Events of this cycle
    sip_core_req_s   core_req_r;         // Registered vector offer
    sip_core_req_s   core_req_nxt;       // Next vector offer
    logic            win_valid;          // Encoder found a request
    logic [2:0]      win_idx;            // Encoder winner
    sip_level_t      win_level;          // Winner level
    logic            floor_valid;        // Some level in service
    sip_level_t      floor_level;        // Highest level in service
    logic [3:0]      reti_clr;           // Level freed by return
    logic [3:0]      take_set;           // Level entered by take
    logic            apb_setup;          // Setup phase
    logic            apb_access;         // Access phase
    logic            addr_hit;           // Address is mapped
    logic            wr_en;              // Write takes effect now
    logic [31:0]     prdata_r;           // Read data register

    // The pins are asynchronous: two flops before any use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext0_sync_r <= 2'b11;
            ext1_sync_r <= 2'b11;
        end else begin
            ext0_sync_r <= {ext0_sync_r[0], ext_req0_pin_n};
            ext1_sync_r <= {ext1_sync_r[0], ext_req1_pin_n};
        end
    end

    // Request vector, one bit per source in poll order
    always_comb begin
        raw_req                  = '0;
        raw_req[`SIP_SRC_EXT0]   = ~ext0_sync_r[1];
        raw_req[`SIP_SRC_TIMER0] = timer0_overflow_flag;
        raw_req[`SIP_SRC_EXT1]   = ~ext1_sync_r[1];
        raw_req[`SIP_SRC_TIMER1] = timer1_overflow_flag;
        raw_req[`SIP_SRC_SERIAL] = serial_receive_flag | serial_send_flag;
        raw_req[`SIP_SRC_TIMER2] = timer2_overflow_flag | timer2_external_flag;
        raw_req[`SIP_SRC_CA]     = counter_array_req;
    end

    // Enable bit n gates source n, bit 7 gates all
    assign gated_req = raw_req & src_en_r[NS-1:0] & {NS{src_en_r[`SIP_GLOBAL_BIT]}};

    // Winner over all gated requests
    sip_prio_enc #(
        .N  (NS),
        .IW (3)
    ) u_enc (
        .pend      (gated_req),
        .lvl_hi    (lvl_high_r),
        .lvl_lo    (lvl_low_r),
        .win_valid (win_valid),
        .win_idx   (win_idx),
        .win_level (win_level)
    );

    // Highest level now in service sets the preemption floor
    always_comb begin
        floor_valid = 1'b0;
        floor_level = '0;
        for (int l = 0; l < 4; l++) begin
            if (inserv_r[l]) begin
                floor_valid = 1'b1;
                floor_level = 2'(l);
            end
        end
    end

    // Offer only a strictly higher level; nothing passes a level 3 handler in service
    always_comb begin
        core_req_nxt        = '0;
        core_req_nxt.src    = win_idx;
        core_req_nxt.level  = win_level;
        core_req_nxt.vector = `SIP_VEC_BASE + (`SIP_VEC_STEP * {13'h0000, win_idx});
        core_req_nxt.valid  = win_valid && (!floor_valid || (win_level > floor_level)) && !core_ack;
    end

    // Offer is dropped after a take so a stale vector is not shown again
    // while the in-service flags settle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_req_r <= '0;
        end else begin
            core_req_r <= core_req_nxt;
        end
    end

    assign core_req = core_req_r;

    // Take sets the offered level; return frees the highest one
    always_comb begin
        take_set = '0;
        reti_clr = '0;
        if (core_ack && core_req_r.valid) begin
            take_set[core_req_r.level] = 1'b1;
        end
        if (core_reti && floor_valid) begin
            reti_clr[floor_level] = 1'b1;
        end
    end

    // In-service flags; a take in the return cycle still sticks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            inserv_r <= '0;
        end else begin
            inserv_r <= (inserv_r & ~reti_clr) | take_set;
        end
    end

    // APB phase and address decode
    assign apb_setup  = psel & ~penable;
    assign apb_access = psel & penable;
    assign wr_en      = apb_access & pwrite & addr_hit;

    always_comb begin
        case (paddr)
            `SIP_OFF_ENABLE, `SIP_OFF_EN_SET, `SIP_OFF_EN_CLR,
            `SIP_OFF_LVL_LOW, `SIP_OFF_LVL_HIGH, `SIP_OFF_INSERVICE,
            `SIP_OFF_EVT_STAT, `SIP_OFF_EVT_MASK: begin
                addr_hit = 1'b1;
            end
            default: begin
                addr_hit = 1'b0;
            end
        endcase
    end

    // Never waits; unmapped addresses answer with an error
    assign pready  = 1'b1;
    assign pslverr = apb_access & ~addr_hit;

    // Source enable: whole write, or set and clear of chosen bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_en_r <= `SIP_ENABLE_RST;
        end else if (wr_en) begin
            case (paddr)
                `SIP_OFF_ENABLE: begin
                    src_en_r <= pwdata[7:0];
                end
                `SIP_OFF_EN_SET: begin
                    src_en_r <= src_en_r | pwdata[7:0];
                end
                `SIP_OFF_EN_CLR: begin
                    src_en_r <= src_en_r & ~pwdata[7:0];
                end
                default: begin
                    src_en_r <= src_en_r;
                end
            endcase
        end
    end

    // Level bits; bit 7 of the low register is not stored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lvl_low_r  <= `SIP_LVL_RST;
            lvl_high_r <= `SIP_LVL_RST;
        end else if (wr_en) begin
            if (paddr == `SIP_OFF_LVL_LOW) begin
                lvl_low_r <= pwdata[NS-1:0];
            end
            if (paddr == `SIP_OFF_LVL_HIGH) begin
                lvl_high_r <= pwdata[NS-1:0];
            end
        end
    end

    // Events: take, return, return with nothing in service, reserved write
    always_comb begin
        evt_set                 = '0;
        evt_set[`SIP_EVT_TAKEN]  = core_ack & core_req_r.valid;
        evt_set[`SIP_EVT_RETURN] = core_reti & floor_valid;
        evt_set[`SIP_EVT_STRAY]  = core_reti & ~floor_valid;
        evt_set[`SIP_EVT_RSVD]   = wr_en & (paddr == `SIP_OFF_LVL_LOW) & pwdata[`SIP_RSVD_BIT];
    end

    // Sticky status, write one to clear; a new event wins the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_stat_r <= '0;
        end else if (wr_en && (paddr == `SIP_OFF_EVT_STAT)) begin
            evt_stat_r <= (evt_stat_r & ~pwdata[NE-1:0]) | evt_set;
        end else begin
            evt_stat_r <= evt_stat_r | evt_set;
        end
    end

    // Event mask
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_mask_r <= '0;
        end else if (wr_en && (paddr == `SIP_OFF_EVT_MASK)) begin
            evt_mask_r <= pwdata[NE-1:0];
        end
    end

    // Level output straight from the two registers
    assign irq = |(evt_stat_r & evt_mask_r);

    // Read data is caught in setup, shown in access; reserved bits read zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= '0;
        end else if (apb_setup && !pwrite) begin
            case (paddr)
                `SIP_OFF_ENABLE, `SIP_OFF_EN_SET, `SIP_OFF_EN_CLR: begin
                    prdata_r <= {24'h000000, src_en_r};
                end
                `SIP_OFF_LVL_LOW: begin
                    prdata_r <= {25'h0000000, lvl_low_r};
                end
                `SIP_OFF_LVL_HIGH: begin
                    prdata_r <= {25'h0000000, lvl_high_r};
                end
                `SIP_OFF_INSERVICE: begin
                    prdata_r <= {28'h0000000, inserv_r};
                end
                `SIP_OFF_EVT_STAT: begin
                    prdata_r <= {28'h0000000, evt_stat_r};
                end
                `SIP_OFF_EVT_MASK: begin
                    prdata_r <= {28'h0000000, evt_mask_r};
                end
                default: begin
                    prdata_r <= '0;
                end
            endcase
        end
    end

    assign prdata = prdata_r;

    // Helpers seen only by the checks below
    logic [NS-1:0] gated_q;      // Gated requests one cycle back
    logic [NS-1:0] beat_lvl;     // Pending with higher level than offer
    logic [NS-1:0] beat_ord;     // Same level, earlier in poll order
    logic [7:0]    en_q;         // Enable register one cycle back
    sip_level_t    floor_q;      // Floor one cycle back
    logic          floor_v_q;    // Floor valid one cycle back
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gated_q   <= '0;
            en_q      <= '0;
            floor_q   <= '0;
            floor_v_q <= 1'b0;
        end else begin
            gated_q   <= gated_req;
            en_q      <= src_en_r;
            floor_q   <= floor_level;
            floor_v_q <= floor_valid;
        end
    end
    always_comb begin
        beat_lvl = '0;
        beat_ord = '0;
        for (int i = 0; i < NS; i++) begin
            beat_lvl[i] = gated_q[i] && ({lvl_high_r[i], lvl_low_r[i]} > core_req_r.level);
            beat_ord[i] = gated_q[i] && ({lvl_high_r[i], lvl_low_r[i]} == core_req_r.level)
                          && (i < int'(core_req_r.src));
        end
    end

    sequence s_take;
        core_ack && core_req_r.valid;
    endsequence

    sequence s_apb_wr(logic [AW-1:0] a);
        psel && penable && pwrite && (paddr == a);
    endsequence

    property p_global_off;
        @(posedge pclk) disable iff (!presetn)
        !src_en_r[`SIP_GLOBAL_BIT] |=> !core_req_r.valid;
    endproperty
    a_global_off: assert property (p_global_off) else $error("offer with global enable clear");

    property p_src_masked;
        @(posedge pclk) disable iff (!presetn)
        core_req_r.valid |-> gated_q[core_req_r.src] && en_q[core_req_r.src];
    endproperty
    a_src_masked: assert property (p_src_masked) else $error("masked source offered");

    property p_vector;
        @(posedge pclk) disable iff (!presetn)
        core_req_r.valid && (core_req_r.src == 3'(`SIP_SRC_CA)) |-> core_req_r.vector == `SIP_VEC_CA;
    endproperty
    a_vector: assert property (p_vector) else $error("wrong counter array vector");

    property p_top_level;
        @(posedge pclk) disable iff (!presetn)
        inserv_r[3] |=> !core_req_r.valid;
    endproperty
    a_top_level: assert property (p_top_level) else $error("top level handler preempted");

    property p_strict_higher;
        @(posedge pclk) disable iff (!presetn)
        core_req_r.valid && floor_v_q |-> core_req_r.level > floor_q;
    endproperty
    a_strict_higher: assert property (p_strict_higher) else $error("preempt by equal or lower level");

    property p_highest_first;
        @(posedge pclk) disable iff (!presetn)
        core_req_r.valid |-> beat_lvl == '0;
    endproperty
    a_highest_first: assert property (p_highest_first) else $error("lower level offered first");

    property p_poll_order;
        @(posedge pclk) disable iff (!presetn)
        core_req_r.valid |-> beat_ord == '0;
    endproperty
    a_poll_order: assert property (p_poll_order) else $error("poll order broken");

    property p_take_marks;
        @(posedge pclk) disable iff (!presetn)
        s_take |=> inserv_r[$past(core_req_r.level)] && !core_req_r.valid;
    endproperty
    a_take_marks: assert property (p_take_marks) else $error("take did not mark level");

    property p_reset_en;
        @(posedge pclk) disable iff (!presetn)
        $rose(presetn) |-> src_en_r == `SIP_ENABLE_RST;
    endproperty
    a_reset_en: assert property (p_reset_en) else $error("enable not clear after reset");

    property p_bit_set;
        @(posedge pclk) disable iff (!presetn)
        s_apb_wr(`SIP_OFF_EN_SET) |=> src_en_r == ($past(src_en_r) | $past(pwdata[7:0]));
    endproperty
    a_bit_set: assert property (p_bit_set) else $error("enable set access wrong");

    property p_rsvd;
        @(posedge pclk) disable iff (!presetn)
        s_apb_wr(`SIP_OFF_LVL_LOW) ##0 pwdata[`SIP_RSVD_BIT] |=> evt_stat_r[`SIP_EVT_RSVD]
            && (lvl_low_r == $past(pwdata[NS-1:0]));
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved write not flagged");
endmodule

/* src/sip_pkg.sv */
// Types shared by the interrupt priority controller files
package sip_pkg;
    typedef logic [1:0] sip_level_t;    // Two-bit priority level

    // Vectored request handed to the core
    typedef struct packed {
        logic        valid;
        logic [2:0]  src;
        sip_level_t  level;
        logic [15:0] vector;
    } sip_core_req_s;
endpackage

/* src/sip_prio_enc.sv */
// Highest-level, first-in-poll-order winner selection
`timescale 1ns/1ns
module sip_prio_enc #(
    parameter int N  = 7,
    parameter int IW = 3
) (
    input  wire logic [N-1:0]      pend,       // Gated pending requests
    input  wire logic [N-1:0]      lvl_hi,     // High level bit per source
    input  wire logic [N-1:0]      lvl_lo,     // Low level bit per source
    output logic                   win_valid,  // Some request pending
    output logic [IW-1:0]          win_idx,    // Winning source index
    output sip_pkg::sip_level_t    win_level   // Level of the winner
);
    import sip_pkg::*;

    // Later assignments override: levels ascend, indices descend,
    // so the last hit is highest level and earliest in poll order
    always_comb begin
        win_valid = 1'b0;
        win_idx   = '0;
        win_level = '0;
        for (int l = 0; l < 4; l++) begin
            for (int i = N - 1; i >= 0; i--) begin
                // Level is high bit over low bit
                if (pend[i] && ({lvl_hi[i], lvl_lo[i]} == 2'(l))) begin
                    win_valid = 1'b1;
                    win_idx   = IW'(i);
                    win_level = 2'(l);
                end
            end
        end
    end
endmodule

/* tb/sip_core_model.sv */
// Processor core model: takes offered vectors and returns from handlers
`timescale 1ns/1ns
module sip_core_model (
    input  wire logic                  pclk,      // Core clock
    input  wire logic                  presetn,   // Async reset, active low
    input  wire sip_pkg::sip_core_req_s core_req, // Offer from the controller
    input  wire logic                  ack_en,    // Core accepts vectors
    input  wire logic [1:0]            ack_dly,   // Extra cycles before taking
    input  wire logic                  reti_cmd,  // Bench asks for a return
    output logic                       core_ack,  // Take pulse
    output logic                       core_reti, // Return pulse
    output logic [2:0]                 last_src,  // Source of last take
    output logic [15:0]                last_vec,  // Vector of last take
    output logic [7:0]                 takes      // Count of takes
);
    import sip_pkg::*;
    logic [1:0] wait_r;  // Cycles the offer has stood
    logic       go;      // Offer standing and core willing
    assign go = core_req.valid && ack_en && !core_ack;
    // Slow answers: the offer may change while the core hesitates
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_ack <= 1'b0;
            wait_r   <= 2'h0;
        end else begin
            core_ack <= go && wait_r == ack_dly;
            wait_r   <= (go && wait_r != ack_dly) ? wait_r + 2'h1 : 2'h0;
        end
    end
    // Record only a take that lands while the offer still stands
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            takes    <= 8'h00;
            last_src <= 3'h0;
            last_vec <= 16'h0000;
        end else if (core_ack && core_req.valid) begin
            takes    <= takes + 8'h01;
            last_src <= core_req.src;
            last_vec <= core_req.vector;
        end
    end
    // Return pulse one cycle after the command
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_reti <= 1'b0;
        end else begin
            core_reti <= reti_cmd;
        end
    end
endmodule

/* tb/tb.sv */
// Self-checking bench of the interrupt priority controller
`timescale 1ns/1ns
`include "sip_cfg.svh"
module tb;
    import sip_pkg::*;
    logic          pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [11:0]   paddr;
    logic [31:0]   pwdata, prdata;
    logic [6:0]    req_v;     // Requests by source index
    logic          alt;       // Picks which flag feeds the shared sources
    logic          core_ack, core_reti, ack_en, reti_cmd;
    logic [1:0]    ack_dly;   // Core answer speed
    logic [2:0]    last_src;
    logic [15:0]   last_vec;
    logic [7:0]    takes;
    sip_core_req_s core_req;
    int            failures, checks_done;
    sip_ctrl #(.AW(12)) DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .ext_req0_pin_n(~req_v[0]), .ext_req1_pin_n(~req_v[2]), .timer0_overflow_flag(req_v[1]),
        .timer1_overflow_flag(req_v[3]), .timer2_overflow_flag(req_v[5] & ~alt),
        .timer2_external_flag(req_v[5] & alt), .serial_receive_flag(req_v[4] & ~alt),
        .serial_send_flag(req_v[4] & alt), .counter_array_req(req_v[6]), .core_req, .core_ack, .core_reti, .irq);
    sip_core_model core (.pclk, .presetn, .core_req, .ack_en, .ack_dly, .reti_cmd, .core_ack, .core_reti,
        .last_src, .last_vec, .takes);
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic print_verdict;
        $display("Checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic expire;
        failures++;
        $display("Error wait expected done seen timeout");
        print_verdict;
    endtask
    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) expire;
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        chk(nm, exp, q);
    endtask
    task automatic chk_irq(input logic x);
        @(negedge pclk);
        chk("irq", {31'h0, x}, {31'h0, irq});
    endtask
    // Request change, then the pin sync plus offer latency of the note
    task automatic setq(input int i, input logic v);
        @(posedge pclk);
        req_v[i] <= v;
        repeat (4) @(posedge pclk);
    endtask
    // No offer may appear while blocked
    task automatic quiet;
        logic s;
        s = 1'b0;
        // The offer is registered, so it may stand one cycle past the enable change
        @(posedge pclk);
        repeat (6) begin
            @(negedge pclk);
            s = s | core_req.valid;
        end
        chk("offer while blocked", 32'h0, {31'h0, s});
    endtask
    // Let the core take one vector and judge source and address
    task automatic take(input int i);
        logic [7:0] t0;
        int         n;
        t0 = takes;
        @(posedge pclk);
        ack_en <= 1'b1;
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while (takes === t0 && n < 60);
        if (n >= 60) expire;
        @(posedge pclk);
        ack_en <= 1'b0;
        chk("taken source", 32'(i), {29'h0, last_src});
        chk("taken vector", 32'h3 + 32'h8 * i, {16'h0, last_vec});
    endtask
    task automatic reti;
        @(posedge pclk);
        reti_cmd <= 1'b1;
        @(posedge pclk);
        reti_cmd <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask
    task automatic t_regs;
        logic [31:0] q;
        logic        e;
        rdc("enable reset", `SIP_OFF_ENABLE, 32'h0);
        rdc("level low reset", `SIP_OFF_LVL_LOW, 32'h0);
        apb(1'b0, 12'h0fc, 32'h0, q, e);
        chk("unmapped error", 32'h1, {31'h0, e});
        wr(`SIP_OFF_ENABLE, 32'hff);
        rdc("enable all", `SIP_OFF_ENABLE, 32'hff);
        wr(`SIP_OFF_EN_CLR, 32'h81);
        rdc("enable clear", `SIP_OFF_ENABLE, 32'h7e);
        wr(`SIP_OFF_EN_SET, 32'h80);
        rdc("enable set", `SIP_OFF_ENABLE, 32'hfe);
        wr(`SIP_OFF_LVL_LOW, 32'hff);
        rdc("level low", `SIP_OFF_LVL_LOW, 32'h7f);
        rdc("event status", `SIP_OFF_EVT_STAT, 32'h8);
        wr(`SIP_OFF_EVT_MASK, 32'h8);
        chk_irq(1'b1);
        wr(`SIP_OFF_EVT_MASK, 32'h0);
        chk_irq(1'b0);
        wr(`SIP_OFF_EVT_MASK, 32'h8);
        wr(`SIP_OFF_EVT_STAT, 32'h8);
        chk_irq(1'b0);
        wr(`SIP_OFF_EVT_MASK, 32'h0);
        wr(`SIP_OFF_LVL_LOW, 32'h0);
        $display("Test registers done");
    endtask
    task automatic t_gate;
        setq(1, 1'b1);
        wr(`SIP_OFF_ENABLE, 32'h7d);
        quiet;
        wr(`SIP_OFF_ENABLE, 32'h02);
        quiet;
        wr(`SIP_OFF_ENABLE, 32'h82);
        take(1);
        rdc("in service", `SIP_OFF_INSERVICE, 32'h1);
        setq(1, 1'b0);
        reti;
        rdc("in service", `SIP_OFF_INSERVICE, 32'h0);
        reti;
        rdc("take return stray", `SIP_OFF_EVT_STAT, 32'h7);
        $display("Test gating done");
    endtask
    task automatic t_poll;
        wr(`SIP_OFF_ENABLE, 32'hff);
        @(posedge pclk);
        req_v <= 7'h7f;
        repeat (4) @(posedge pclk);
        for (int i = 0; i < 7; i++) begin
            take(i);
            quiet;
            setq(i, 1'b0);
            reti;
        end
        $display("Test polling done");
    endtask
    task automatic t_levels;
        wr(`SIP_OFF_LVL_LOW, 32'h0c);
        wr(`SIP_OFF_LVL_HIGH, 32'h14);
        rdc("level high", `SIP_OFF_LVL_HIGH, 32'h14);
        @(posedge pclk);
        alt     <= 1'b1;
        ack_dly <= 2'h2;
        req_v   <= 7'h1c;
        repeat (4) @(posedge pclk);
        take(2);
        quiet;
        rdc("in service", `SIP_OFF_INSERVICE, 32'h8);
        setq(2, 1'b0);
        reti;
        take(4);
        quiet;
        setq(2, 1'b1);
        take(2);
        rdc("in service", `SIP_OFF_INSERVICE, 32'hc);
        setq(2, 1'b0);
        reti;
        setq(4, 1'b0);
        reti;
        take(3);
        setq(3, 1'b0);
        reti;
        $display("Test levels done");
    endtask
    initial begin
        failures    = 0;
        checks_done = 0;
        presetn     = 1'b0;
        psel        = 1'b0;
        penable     = 1'b0;
        pwrite      = 1'b0;
        paddr       = 12'h000;
        pwdata      = 32'h0;
        req_v       = 7'h00;
        alt         = 1'b0;
        ack_en      = 1'b0;
        ack_dly     = 2'h0;
        reti_cmd    = 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_gate;
        t_poll;
        t_levels;
        print_verdict;
    end
endmodule
